// *** logic/epc_top.sv ***
// Event pin configuration logic with APB register access
`timescale 1ns/1ps
module epc_top
	import epc_pkg::*;
(
	input  wire logic        i_sys_clk,      // System clock, 40 MHz
	input  wire logic        i_rst_n,        // Async reset, active low
	input  wire logic        i_clk_en,       // Clock enable, freezes state
	// APB slave
	input  wire logic        i_psel,         // APB select
	input  wire logic        i_penable,      // APB enable
	input  wire logic        i_pwrite,       // APB direction
	input  wire logic [7:0]  i_paddr,        // APB byte address
	input  wire logic [31:0] i_pwdata,       // APB write data
	input  wire logic [3:0]  i_pstrb,        // APB byte strobes
	output logic             o_pready,       // APB ready
	output logic [31:0]      o_prdata,       // APB read data
	output logic             o_pslverr,      // APB error
	// Internal device events
	input  wire logic        i_busy,         // Device busy level
	input  wire logic        i_double_error, // 2-bit ECC detection pulse
	input  wire logic        i_single_error, // 1-bit ECC correction pulse
	// Open-drain event pin
	input  wire logic        i_event_pin_i,  // Pin level sensed
	output logic             o_event_pin_o,  // Pin output value
	output logic             o_event_pin_oe, // Pin pull-low enable
	// Interrupt
	output logic             o_irq           // Level interrupt
);

	typedef struct packed {
		logic [7:0]  cfg;
		logic [7:0]  mask;
		logic        busy_prev;
		logic        drive;
		logic [1:0]  pin_sync;
		logic [31:0] rdata;
		logic        irq;
	} epc_state_t;

	epc_state_t st_reg;
	epc_state_t st_next;

	logic [EPC_NUM_SRC-1:0] src_event;
	logic [EPC_NUM_SRC-1:0] src_select;
	logic [EPC_NUM_SRC-1:0] src_clear;
	logic [EPC_NUM_SRC-1:0] src_flag_n;
	logic [EPC_NUM_SRC-1:0] src_pending;
	logic [EPC_NUM_SRC-1:0] src_irq_req;
	logic [7:0]             flags;
	logic [7:0]             state_word;
	logic                   setup_phase;
	logic                   access_phase;
	logic                   wr_take;
	logic                   rd_setup;
	logic                   hit_config;
	logic                   hit_flags;
	logic                   hit_mask;
	logic                   hit_state;
	logic                   addr_hit;
	logic                   lane0_wr;
	logic                   fn_enabled;
	logic                   ready_event;
	logic                   any_selected_set;
	logic                   any_unmasked;

	// APB phase decode
	assign setup_phase  = i_psel && !i_penable;
	assign access_phase = i_psel && i_penable;
	assign wr_take      = access_phase && i_pwrite && i_clk_en;
	assign rd_setup     = setup_phase && !i_pwrite;
	assign lane0_wr     = wr_take && i_pstrb[0];

	// Address decode
	assign hit_config = (i_paddr == EPC_CONFIG_OFF);
	assign hit_flags  = (i_paddr == EPC_FLAGS_OFF);
	assign hit_mask   = (i_paddr == EPC_MASK_OFF);
	assign hit_state  = (i_paddr == EPC_STATE_OFF);
	assign addr_hit   = hit_config || hit_flags || hit_mask || hit_state;

	// function enabled when bit is 0
	assign fn_enabled = !st_reg.cfg[EPC_FN_DIS_BIT];

	assign ready_event = st_reg.busy_prev && !i_busy;

	// Event routing per source
	assign src_event[0] = i_single_error;
	assign src_event[1] = i_double_error;
	assign src_event[2] = ready_event;

	// Per-source flag cells
	genvar g;
	generate
		for (g = 0; g < EPC_NUM_SRC; g = g + 1) begin : g_src
			assign src_select[g] = fn_enabled && !st_reg.cfg[EPC_SRC_POS[g]];
			assign src_clear[g] = lane0_wr && hit_flags
				&& i_pwdata[EPC_SRC_POS[g]];

			epc_flag_cell u_flag (
				.i_sys_clk (i_sys_clk),
				.i_rst_n   (i_rst_n),
				.i_clk_en  (i_clk_en),
				.i_event   (src_event[g]),
				.i_select  (src_select[g]),
				.i_clear   (src_clear[g]),
				.o_flag_n  (src_flag_n[g])
			);

			assign src_pending[g] = !src_flag_n[g] && !st_reg.cfg[EPC_SRC_POS[g]];
			// Unmasked flag feeds interrupt
			assign src_irq_req[g] = !src_flag_n[g] && st_reg.mask[EPC_SRC_POS[g]];
		end
	endgenerate

	// flag word, reserved bits read 1
	always_comb begin
		flags = EPC_FLAGS_RST;
		for (int k = 0; k < EPC_NUM_SRC; k++) begin
			flags[EPC_SRC_POS[k]] = src_flag_n[k];
		end
	end

	// Selected flag pending and unmasked flag pending
	assign any_selected_set = |src_pending;
	assign any_unmasked     = |src_irq_req;

	// Block state word
	always_comb begin
		state_word                   = 8'h00;
		state_word[EPC_ST_DRIVE_BIT] = st_reg.drive;
		state_word[EPC_ST_PIN_BIT]   = st_reg.pin_sync[1];
		state_word[EPC_ST_BUSY_BIT]  = st_reg.busy_prev;
		state_word[EPC_ST_FN_EN_BIT] = fn_enabled;
		state_word[EPC_ST_IRQ_BIT]   = st_reg.irq;
	end

	// Next state
	always_comb begin
		st_next = st_reg;

		st_next.busy_prev = i_busy;
		st_next.pin_sync  = {st_reg.pin_sync[0], i_event_pin_i};

		// hold low while selected flag set
		st_next.drive = fn_enabled && any_selected_set;

		st_next.irq = any_unmasked;

		// Configuration write, flags untouched
		if (lane0_wr && hit_config) begin
			st_next.cfg = i_pwdata[7:0];
		end

		if (lane0_wr && hit_mask) begin
			st_next.mask = i_pwdata[7:0];
		end

		// Read data captured in setup phase
		if (rd_setup) begin
			case (1'b1)
				hit_config: st_next.rdata = {24'h000000, st_reg.cfg};
				hit_flags:  st_next.rdata = {24'h000000, flags};
				hit_mask:   st_next.rdata = {24'h000000, st_reg.mask};
				hit_state:  st_next.rdata = {24'h000000, state_word};
				default:    st_next.rdata = 32'h00000000;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg.cfg       <= EPC_CONFIG_RST;
			st_reg.mask      <= EPC_MASK_RST;
			st_reg.busy_prev <= 1'b0;
			st_reg.drive     <= 1'b0;
			st_reg.pin_sync  <= 2'b11;
			st_reg.rdata     <= 32'h00000000;
			st_reg.irq       <= 1'b0;
		end else if (i_clk_en) begin
			st_reg <= st_next;
		end
	end

	// APB answer, stalls while clock enable is low
	// Read data is captured in setup: keep clock enable high there
	assign o_pready  = i_clk_en;
	assign o_prdata  = st_reg.rdata;
	assign o_pslverr = access_phase && !addr_hit;

	assign o_event_pin_o  = 1'b0;
	assign o_event_pin_oe = st_reg.drive;

	assign o_irq = st_reg.irq;

endmodule : epc_top

// *** common/epc_pkg.sv ***
// Constants for the event pin configuration block
//
// Behaviour
// - Pin function disable bit 7 at 1 keeps the event pin released.
// - Event pin is open drain: only pulls low, never drives high.
// - Ready select bit 4 at 0: busy-to-ready transition pulls pin low.
// - Double error select bit 1 at 0: 2-bit ECC detection pulls pin low.
// - Single error select bit 0 at 0: 1-bit ECC correction pulls pin low.
// - A deselected source also cannot update its status flag.
// - Writing a select bit to deselect leaves recorded flags untouched.
// - Volatile flag register records selected events since last clear.
// - Flags active low: bit 4 ready, bit 1 double, bit 0 single; reset 1.
package epc_pkg;

	// APB register offsets (byte addresses)
	localparam logic [7:0] EPC_CONFIG_OFF   = 8'h00;
	localparam logic [7:0] EPC_FLAGS_OFF    = 8'h04;
	localparam logic [7:0] EPC_MASK_OFF     = 8'h08;
	localparam logic [7:0] EPC_STATE_OFF    = 8'h0c;

	// Configuration and flag field positions
	localparam int         EPC_FN_DIS_BIT   = 7;
	localparam int         EPC_READY_BIT    = 4;
	localparam int         EPC_DOUBLE_BIT   = 1;
	localparam int         EPC_SINGLE_BIT   = 0;
	localparam int         EPC_NUM_SRC      = 3;

	// Source index to bit position
	localparam int         EPC_SRC_POS [EPC_NUM_SRC] = '{EPC_SINGLE_BIT,
	                                                     EPC_DOUBLE_BIT,
	                                                     EPC_READY_BIT};

	// Reset values
	localparam logic [7:0] EPC_CONFIG_RST   = 8'hff;
	localparam logic [7:0] EPC_FLAGS_RST    = 8'hff;
	localparam logic [7:0] EPC_MASK_RST     = 8'h00;

	// Block state register fields
	localparam int         EPC_ST_DRIVE_BIT = 0;
	localparam int         EPC_ST_PIN_BIT   = 1;
	localparam int         EPC_ST_BUSY_BIT  = 2;
	localparam int         EPC_ST_FN_EN_BIT = 3;
	localparam int         EPC_ST_IRQ_BIT   = 4;

endpackage : epc_pkg

// *** logic/epc_flag_cell.sv ***
// One active-low sticky event flag
`timescale 1ns/1ps
module epc_flag_cell
	import epc_pkg::*;
(
	input  wire logic i_sys_clk,  // System clock
	input  wire logic i_rst_n,    // Async reset, active low
	input  wire logic i_clk_en,   // Clock enable
	input  wire logic i_event,    // Event pulse
	input  wire logic i_select,   // Source selected (config bit at 0)
	input  wire logic i_clear,    // Write-one restore to 1
	output logic      o_flag_n    // Flag, 0 when event recorded
);

	typedef struct packed {
		logic flag_n;
	} epc_cell_t;

	epc_cell_t cell_reg;
	epc_cell_t cell_next;

	always_comb begin
		cell_next = cell_reg;
		if (i_event && i_select) begin
			cell_next.flag_n = 1'b0;
		end else if (i_clear) begin
			cell_next.flag_n = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cell_reg.flag_n <= 1'b1;
		end else if (i_clk_en) begin
			cell_reg <= cell_next;
		end
	end

	assign o_flag_n = cell_reg.flag_n;

endmodule : epc_flag_cell

// *** testbench/epc_host_pin.sv ***
// Host side of the open-drain event pin
`timescale 1ns/1ps
module epc_host_pin (
	input  wire logic i_oe,    // Device pulls low
	input  wire logic i_drv,   // Device output value
	output logic      o_level  // Resolved pin level
);
	assign o_level = i_oe ? i_drv : 1'b1;
endmodule : epc_host_pin

// *** testbench/epc_top_sva.sv ***
// Checker for the event pin block
`timescale 1ns/1ps
module epc_top_sva (
	input wire logic        i_sys_clk, i_rst_n, i_clk_en, i_psel, i_penable, i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0]  i_pstrb,
	input wire logic        o_pready, o_pslverr, o_event_pin_o, o_event_pin_oe,
	input wire logic        i_busy, i_double_error, i_single_error
);
	logic [7:0] cfg_reg;
	logic       en;
	// Shadow of the configuration register
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_reg <= 8'hff;
		end else if (i_clk_en && i_psel && i_penable && i_pwrite && i_pstrb[0]
				&& i_paddr == 8'h00) begin
			cfg_reg <= i_pwdata[7:0];
		end
	end
	assign en = i_clk_en && !cfg_reg[7];
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	AST_OPEN_DRAIN: assert property (o_event_pin_o == 1'b0)
		else $error("pin driven high");
	AST_READY: assert property (o_pready == i_clk_en)
		else $error("pready not tied to clock enable");
	AST_UNMAPPED: assert property (i_psel && i_penable
		&& !(i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |-> o_pslverr)
		else $error("no error on unmapped address");
	AST_SINGLE: assert property (en && !cfg_reg[0] && i_single_error
		##1 (en && !cfg_reg[0]) |=> o_event_pin_oe)
		else $error("single error did not pull pin");
	AST_DOUBLE: assert property (en && !cfg_reg[1] && i_double_error
		##1 (en && !cfg_reg[1]) |=> o_event_pin_oe)
		else $error("double error did not pull pin");
	AST_BUSY: assert property ($past(i_rst_n) && $past(i_clk_en) && en && !cfg_reg[4]
		&& $fell(i_busy) ##1 (en && !cfg_reg[4]) |=> o_event_pin_oe)
		else $error("ready transition did not pull pin");
	AST_DISABLED: assert property ($past(i_clk_en) && cfg_reg[7] && $past(cfg_reg[7])
		|-> !o_event_pin_oe) else $error("pin pulled while function disabled");
	AST_DESELECT: assert property ($past(i_clk_en) && &{cfg_reg[4], cfg_reg[1:0]}
		&& $past(&{cfg_reg[4], cfg_reg[1:0]}) |-> !o_event_pin_oe)
		else $error("pin pulled with all sources deselected");
	cover property (o_event_pin_oe ##1 !o_event_pin_oe);
	cover property (o_pslverr);
	cover property (en && $fell(i_busy));
endmodule : epc_top_sva

bind epc_top epc_top_sva i_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
	.o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_event_pin_o(o_event_pin_o), .o_event_pin_oe(o_event_pin_oe), .i_busy(i_busy),
	.i_double_error(i_double_error), .i_single_error(i_single_error));

// *** testbench/epc_top_tb.sv ***
// Self-checking bench for the event pin block
`timescale 1ns/1ps
module epc_top_tb;
	import epc_pkg::*;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, busy = 0, derr = 0, serr = 0;
	logic        cen = 1'b1;
	logic [3:0]  strb = 4'hf;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic        pready, perr, pin_o, pin_oe, irq, pin;
	int          n_fail = 0, check_count = 0;
	always #12.5 clk = ~clk;
	epc_top i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(cen), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb),
		.o_pready(pready), .o_prdata(rd), .o_pslverr(perr), .i_busy(busy),
		.i_double_error(derr), .i_single_error(serr), .i_event_pin_i(pin),
		.o_event_pin_o(pin_o), .o_event_pin_oe(pin_oe), .o_irq(irq));
	epc_host_pin i_host (.i_oe(pin_oe), .i_drv(pin_o), .o_level(pin));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			conclude();
		end
		r = rd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk("prdata", exp, r);
		chk("pslverr", {31'h0, xe}, {31'h0, e});
	endtask : rdchk
	// Event pulse: 0 single, 1 double, 2 busy then ready
	task automatic pulse(input int k);
		@(posedge clk);
		serr <= (k == 0);
		derr <= (k == 1);
		busy <= (k == 2);
		@(posedge clk);
		serr <= 1'b0;
		derr <= 1'b0;
		busy <= 1'b0;
	endtask : pulse
	task automatic pins(input logic oe, input logic q);
		repeat (4) @(posedge clk);
		#1;
		chk("oe", {31'h0, oe}, {31'h0, pin_oe});
		chk("pin", {31'h0, ~oe}, {31'h0, pin});
		chk("irq", {31'h0, q}, {31'h0, irq});
	endtask : pins
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(EPC_CONFIG_OFF, 32'hff, 1'b0);
		rdchk(EPC_FLAGS_OFF, 32'hff, 1'b0);
		rdchk(EPC_MASK_OFF, 32'h0, 1'b0);
		rdchk(EPC_STATE_OFF, 32'h2, 1'b0);
		rdchk(8'h10, 32'h0, 1'b1);
		pins(1'b0, 1'b0);
		wr(EPC_MASK_OFF, 8'h13);
		strb <= 4'h0;
		wr(EPC_CONFIG_OFF, 8'h6c);
		strb <= 4'hf;
		rdchk(EPC_CONFIG_OFF, 32'hff, 1'b0);
		wr(EPC_CONFIG_OFF, 8'h7e);
		pulse(1);
		rdchk(EPC_FLAGS_OFF, 32'hff, 1'b0);
		cen <= 1'b0;
		pulse(0);
		cen <= 1'b1;
		rdchk(EPC_FLAGS_OFF, 32'hff, 1'b0);
		pulse(0);
		pins(1'b1, 1'b1);
		rdchk(EPC_FLAGS_OFF, 32'hfe, 1'b0);
		rdchk(EPC_STATE_OFF, 32'h19, 1'b0);
		wr(EPC_CONFIG_OFF, 8'hff);
		pins(1'b0, 1'b1);
		pulse(2);
		rdchk(EPC_FLAGS_OFF, 32'hfe, 1'b0);
		wr(EPC_CONFIG_OFF, 8'h6c);
		pulse(1);
		pulse(2);
		pins(1'b1, 1'b1);
		rdchk(EPC_FLAGS_OFF, 32'hec, 1'b0);
		wr(EPC_FLAGS_OFF, 8'h13);
		pins(1'b0, 1'b0);
		rdchk(EPC_FLAGS_OFF, 32'hff, 1'b0);
		wr(EPC_MASK_OFF, 8'h00);
		pulse(0);
		pins(1'b1, 1'b0);
		conclude();
	end
endmodule : epc_top_tb
